/* File: src/sdio_top.sv */
// Notes on behaviour
// - Home input returns motor to position zero.
// - Power-up position is the electrical home.
// - Position reset zeroes command position, motor stationary.
// - Push mode reuses home/reset pins as selects.
// - Clear outside alarm zeroes deviation counter.
// - Step pulses ignored while clear is on.
// - Clear aborts any return operation.
// - Alarm drops fault output, blinks, cuts current unless keep_current.
// - Resettable alarm clears on reset input fall.
// - Current-control input selects current control mode.
// - Excite input gives ready and accepts pulses.
// - Alarm code shown on shared pins if enabled.
// - Torque flag when out of range or pushing.
// - Complete when no pulse and within 1.8 degrees.
// - Timing output every 7.2 degrees of shaft.
// - Timing only below 10 kHz / 500 Hz.
// - One A pulse per step of motion.
// - B runs at the A rate a quarter cycle behind going CW: one A rise with B low per step.
// - Feedback trails motion by at most 0.1 ms.
// - Warning follows warning or alarm conditions.
// - CW pulse adds a step, CCW subtracts.
`timescale 1ns/1ps
`default_nettype none
`include "sdio_regs.svh"

module sdio_top
	import sdio_pkg::*;
#(
	parameter int DIFF_MIN_CYC = `SDIO_DIFF_MIN_CYC,
	parameter int OC_MIN_CYC = `SDIO_OC_MIN_CYC,
	parameter int BLINK_CYC = `SDIO_BLINK_CYC
) (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Opto inputs, high means current flowing.
	input wire logic STEP_CLOCKWISE,
	input wire logic STEP_COUNTERCLOCKWISE,
	input wire logic EXCITE_IN,
	input wire logic PUSH_CURRENT_SEL0,
	input wire logic HOME_RETURN_IN,
	input wire logic POSITION_RESET_IN,
	input wire logic CLEAR_OR_FAULT_RESET,
	input wire logic CURRENT_CONTROL_SELECT,
	input wire logic RESOLUTION_SELECT,
	// Configuration.
	input wire logic PUSH_MODE_EN,
	input wire logic MODE_SWITCH_CC,
	input wire logic FAULT_CODE_EN,
	input wire logic WARN_OWN_COND_EN,
	input wire logic [15:0] TICK_STEPS,
	// Motor side.
	input wire logic MOTOR_STEP,
	input wire logic MOTOR_CW,
	input wire logic FAULT_COND,
	input wire sdio_fault_t FAULT_INFO,
	input wire logic WARNING_COND,
	input wire logic TORQUE_OVER,
	input wire logic PUSH_ACTIVE,
	// Command to the position loop.
	output logic CMD_STEP,
	output logic CMD_CW,
	output logic signed [31:0] CMD_POSITION,
	output logic signed [31:0] DEVIATION,
	output logic [2:0] PUSH_CURRENT_SEL,
	output logic CURRENT_CONTROL_MODE,
	output logic MOTOR_CURRENT_EN,
	output logic RETURN_ABORT,
	output logic RETURN_BUSY,
	// Status outputs.
	output logic READY_OR_CODE0,
	output logic TORQUE_OR_CODE1,
	output logic MOTION_COMPLETE,
	output logic ROTATION_TICK_DIFF,
	output logic ROTATION_TICK_OC,
	output logic WARNING_OUT,
	output logic FAULT_OUT_N,
	output logic FAULT_LED,
	output logic FEEDBACK_PHASE_A,
	output logic FEEDBACK_PHASE_B
);

	function automatic logic [31:0] sdio_abs(input logic signed [31:0] v);
		sdio_abs = v[31] ? 32'(-v) : 32'(v);
	endfunction : sdio_abs

	logic [`SDIO_IN_W-1:0] s1_r, s2_r, prev_r;
	sdio_state_t state_r, state_nxt;
	logic first_r, alarm_r, tick_block_r, blink_r;
	logic [2:0] code_r;
	logic keep_r, resettable_r;
	logic [15:0] tick_steps_r, tick_cnt_r;
	logic [16:0] gap_r;
	logic [8:0] home_div_r;
	logic [23:0] blink_cnt_r;
	logic signed [31:0] rotor_r;
	sdio_move_t motion_w;

	// Opto inputs pass two flops before any edge or level logic.
	wire [`SDIO_IN_W-1:0] in_raw = {RESOLUTION_SELECT, CURRENT_CONTROL_SELECT,
		CLEAR_OR_FAULT_RESET, POSITION_RESET_IN, HOME_RETURN_IN, PUSH_CURRENT_SEL0,
		EXCITE_IN, STEP_COUNTERCLOCKWISE, STEP_CLOCKWISE};
	wire [`SDIO_IN_W-1:0] rise_w = s2_r & ~prev_r;
	wire [`SDIO_IN_W-1:0] fall_w = ~s2_r & prev_r;

	wire clr_w = s2_r[`SDIO_IN_CLR];
	wire excite_w = s2_r[`SDIO_IN_EXCITE];
	wire ready_w = first_r && excite_w && !alarm_r;
	wire accept_w = ready_w && !clr_w && (state_r == SDIO_IDLE);
	wire cw_w = accept_w && rise_w[`SDIO_IN_CW] && !s2_r[`SDIO_IN_CCW];
	wire ccw_w = accept_w && rise_w[`SDIO_IN_CCW] && !s2_r[`SDIO_IN_CW];
	wire home_go = !PUSH_MODE_EN && rise_w[`SDIO_IN_HOME] && accept_w;
	wire preset_w = !PUSH_MODE_EN && s2_r[`SDIO_IN_PRESET];
	wire home_tick = (home_div_r == 9'(`SDIO_HOME_STEP_CYC - 1));
	wire abort_w = clr_w && (state_r != SDIO_IDLE);
	// Clear gates the return step too, so no step slips out in the cycle clear arrives.
	wire home_step = (state_r == SDIO_HOME) && home_tick && (CMD_POSITION != 32'sh0)
		&& ready_w && !clr_w;
	wire step_w = cw_w || ccw_w || home_step;
	wire dir_w = cw_w || (home_step && CMD_POSITION[31]);
	wire dev_clr = clr_w && !alarm_r;
	wire fault_clr = fall_w[`SDIO_IN_CLR] && alarm_r && resettable_r;
	wire stationary = (gap_r == 17'(OC_MIN_CYC)) && !MOTOR_STEP;
	wire at_tick = (tick_cnt_r == 16'h0);
	wire [31:0] err_w = sdio_abs(CMD_POSITION - rotor_r);
	wire [31:0] tol_w = {18'h0, tick_steps_r[15:2]};
	wire no_pulse = !s2_r[`SDIO_IN_CW] && !s2_r[`SDIO_IN_CCW];
	wire [15:0] tick_top = tick_steps_r - 16'h1;
	wire [15:0] tick_nxt = MOTOR_CW ? (tick_cnt_r >= tick_top ? 16'h0 : tick_cnt_r + 16'h1)
		: (tick_cnt_r == 16'h0 ? tick_top : tick_cnt_r - 16'h1);
	wire tick_ok = at_tick && !tick_block_r;
	wire torque_w = TORQUE_OVER || (PUSH_MODE_EN && PUSH_ACTIVE);
	wire show_code = FAULT_CODE_EN && alarm_r;

	assign motion_w.step = MOTOR_STEP;
	assign motion_w.cw = MOTOR_CW;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SDIO_IDLE: begin
				if (home_go) begin
					state_nxt = SDIO_HOME;
				end
			end
			SDIO_HOME: begin
				if (abort_w || CMD_POSITION == 32'sh0 || !ready_w) begin
					state_nxt = SDIO_IDLE;
				end
			end
			default: begin
				state_nxt = SDIO_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			s1_r <= '0;
			s2_r <= '0;
			prev_r <= '0;
		end else begin
			s1_r <= in_raw;
			s2_r <= s1_r;
			prev_r <= s2_r;
		end
	end

	// Resolution-derived counts are caught once, after reset release.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			first_r <= 1'b0;
			tick_steps_r <= 16'h1;
		end else if (!first_r) begin
			first_r <= 1'b1;
			tick_steps_r <= (TICK_STEPS == 16'h0) ? 16'h1 : TICK_STEPS;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_r <= `SDIO_STATE_RST;
			home_div_r <= 9'h0;
			RETURN_ABORT <= 1'b0;
		end else begin
			state_r <= state_nxt;
			home_div_r <= home_tick ? 9'h0 : home_div_r + 9'h1;
			RETURN_ABORT <= abort_w;
		end
	end

	// Position and deviation start at zero: power-up spot is home.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			CMD_POSITION <= `SDIO_POS_RST;
			rotor_r <= `SDIO_POS_RST;
			DEVIATION <= `SDIO_POS_RST;
			CMD_STEP <= 1'b0;
			CMD_CW <= 1'b0;
		end else begin
			CMD_STEP <= step_w && !preset_w;
			CMD_CW <= dir_w;
			if (preset_w) begin
				CMD_POSITION <= 32'sh0;
				rotor_r <= 32'sh0;
			end else begin
				CMD_POSITION <= CMD_POSITION + (step_w ? (dir_w ? 32'sh1 : -32'sh1) : 32'sh0);
				rotor_r <= rotor_r + (MOTOR_STEP ? (MOTOR_CW ? 32'sh1 : -32'sh1) : 32'sh0);
			end
			if (dev_clr) begin
				DEVIATION <= 32'sh0;
			end else begin
				DEVIATION <= DEVIATION + (step_w ? (dir_w ? 32'sh1 : -32'sh1) : 32'sh0)
					- (MOTOR_STEP ? (MOTOR_CW ? 32'sh1 : -32'sh1) : 32'sh0);
			end
		end
	end

	// A new fault wins over a reset edge arriving in the same cycle.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			alarm_r <= 1'b0;
			code_r <= 3'h0;
			keep_r <= 1'b0;
			resettable_r <= 1'b0;
		end else if (FAULT_COND && !alarm_r) begin
			alarm_r <= 1'b1;
			code_r <= FAULT_INFO.code;
			keep_r <= FAULT_INFO.keep_current;
			resettable_r <= FAULT_INFO.resettable;
		end else if (fault_clr && !FAULT_COND) begin
			alarm_r <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			blink_cnt_r <= 24'h0;
			blink_r <= 1'b0;
		end else if (blink_cnt_r == 24'(BLINK_CYC - 1)) begin
			blink_cnt_r <= 24'h0;
			blink_r <= !blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 24'h1;
		end
	end

	// Gap saturates at the slow limit; it doubles as the standstill test.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			gap_r <= 17'(OC_MIN_CYC);
			tick_cnt_r <= 16'h0;
			tick_block_r <= 1'b0;
		end else begin
			if (MOTOR_STEP) begin
				gap_r <= 17'h0;
				tick_cnt_r <= tick_nxt;
			end else if (gap_r != 17'(OC_MIN_CYC)) begin
				gap_r <= gap_r + 17'h1;
			end
			if ((rise_w[`SDIO_IN_RES] || fall_w[`SDIO_IN_RES]) && !(at_tick && stationary)) begin
				tick_block_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			READY_OR_CODE0 <= 1'b0;
			TORQUE_OR_CODE1 <= 1'b0;
			MOTION_COMPLETE <= 1'b0;
			ROTATION_TICK_DIFF <= 1'b0;
			ROTATION_TICK_OC <= 1'b0;
			WARNING_OUT <= 1'b0;
			FAULT_OUT_N <= 1'b0;
			FAULT_LED <= 1'b0;
			MOTOR_CURRENT_EN <= 1'b0;
			CURRENT_CONTROL_MODE <= 1'b0;
			PUSH_CURRENT_SEL <= 3'h0;
			RETURN_BUSY <= 1'b0;
		end else begin
			READY_OR_CODE0 <= show_code ? code_r[0] : ready_w;
			TORQUE_OR_CODE1 <= show_code ? code_r[1] : torque_w;
			ROTATION_TICK_OC <= show_code ? code_r[2]
				: (tick_ok && gap_r >= 17'(OC_MIN_CYC));
			ROTATION_TICK_DIFF <= tick_ok && gap_r >= 17'(DIFF_MIN_CYC);
			MOTION_COMPLETE <= no_pulse && (err_w <= tol_w);
			WARNING_OUT <= WARN_OWN_COND_EN ? WARNING_COND : FAULT_COND;
			FAULT_OUT_N <= !alarm_r;
			FAULT_LED <= alarm_r && blink_r;
			MOTOR_CURRENT_EN <= excite_w && !(alarm_r && !keep_r);
			CURRENT_CONTROL_MODE <= MODE_SWITCH_CC || s2_r[`SDIO_IN_CCM];
			PUSH_CURRENT_SEL <= PUSH_MODE_EN ? {s2_r[`SDIO_IN_PRESET], s2_r[`SDIO_IN_HOME],
				s2_r[`SDIO_IN_SEL0]} : 3'h0;
			RETURN_BUSY <= (state_nxt == SDIO_HOME);
		end
	end

	sdio_quad u_quad (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.move(motion_w),
		.phase_a(FEEDBACK_PHASE_A),
		.phase_b(FEEDBACK_PHASE_B)
	);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	clr_blocks_step_a: assert property (clr_w |-> ##1 !CMD_STEP || $past(preset_w))
		else $error("Step passed while clear held.");
	preset_zero_a: assert property (preset_w |=> CMD_POSITION == 32'sh0)
		else $error("Position reset did not zero command.");
	dev_clear_a: assert property (dev_clr |=> DEVIATION == 32'sh0)
		else $error("Deviation not cleared.");
	fault_drop_a: assert property ($rose(alarm_r) |=> !FAULT_OUT_N)
		else $error("Fault output not dropped on alarm.");
	fault_reset_a: assert property (fault_clr && !FAULT_COND |-> ##3 FAULT_OUT_N)
		else $error("Alarm not reset on reset falling edge.");
	no_rise_reset_a: assert property (alarm_r && !fall_w[`SDIO_IN_CLR] |=> alarm_r)
		else $error("Alarm cleared without falling edge.");
	current_cut_a: assert property (alarm_r && !keep_r |=> !MOTOR_CURRENT_EN)
		else $error("Current not cut on alarm.");
	home_abort_a: assert property (abort_w |=> state_r == SDIO_IDLE && RETURN_ABORT)
		else $error("Return not aborted by clear.");
	ready_gate_a: assert property (!excite_w |=> !READY_OR_CODE0 || $past(show_code))
		else $error("Ready shown without excitation.");
	code_out_a: assert property (show_code |=> READY_OR_CODE0 == $past(code_r[0]))
		else $error("Fault code bit 0 wrong.");
	push_sel_a: assert property (PUSH_MODE_EN |=> !RETURN_BUSY && !$past(preset_w))
		else $error("Shared pins acted as home or reset in push mode.");
	torque_a: assert property (PUSH_MODE_EN && PUSH_ACTIVE && !show_code
		|=> TORQUE_OR_CODE1)
		else $error("Torque flag low while pushing.");
	tick_fast_a: assert property (gap_r < 17'(DIFF_MIN_CYC) |=> !ROTATION_TICK_DIFF)
		else $error("Timing output at too high a rate.");
	cc_mode_a: assert property (MODE_SWITCH_CC |=> CURRENT_CONTROL_MODE)
		else $error("Current control mode lost.");

	home_cov_c: cover property (home_go ##[1:1000] state_r == SDIO_IDLE);
	alarm_cov_c: cover property ($rose(alarm_r) ##[1:300] fault_clr);
	tick_cov_c: cover property ($rose(ROTATION_TICK_DIFF));
	end_cov_c: cover property ($rose(MOTION_COMPLETE));

endmodule : sdio_top
`default_nettype wire

/* File: pkg/sdio_regs.svh */
`ifndef SDIO_REGS_SVH
`define SDIO_REGS_SVH

// Clock rate and timing figures.
`define SDIO_CLK_HZ 50000000
`define SDIO_DIFF_RATE_HZ 10000
`define SDIO_OC_RATE_HZ 500
`define SDIO_DIFF_MIN_CYC (`SDIO_CLK_HZ / `SDIO_DIFF_RATE_HZ)
`define SDIO_OC_MIN_CYC (`SDIO_CLK_HZ / `SDIO_OC_RATE_HZ)
`define SDIO_FB_LAG_NS 100000
`define SDIO_FB_LAG_CYC ((`SDIO_FB_LAG_NS * (`SDIO_CLK_HZ / 1000000)) / 1000)
`define SDIO_FB_QTR_CYC 25
`define SDIO_HOME_STEP_CYC 500
`define SDIO_BLINK_CYC 12500000

// Bit positions in the synchronised input vector.
`define SDIO_IN_CW 0
`define SDIO_IN_CCW 1
`define SDIO_IN_EXCITE 2
`define SDIO_IN_SEL0 3
`define SDIO_IN_HOME 4
`define SDIO_IN_PRESET 5
`define SDIO_IN_CLR 6
`define SDIO_IN_CCM 7
`define SDIO_IN_RES 8
`define SDIO_IN_W 9

// Reset values.
`define SDIO_POS_RST 32'sh0
`define SDIO_STATE_RST SDIO_IDLE

`endif

/* File: pkg/sdio_pkg.sv */
package sdio_pkg;

	typedef enum logic [0:0] {
		SDIO_IDLE = 1'b0,
		SDIO_HOME = 1'b1
	} sdio_state_t;

	typedef struct packed {
		logic resettable;
		logic keep_current;
		logic [2:0] code;
	} sdio_fault_t;

	typedef struct packed {
		logic step;
		logic cw;
	} sdio_move_t;

endpackage : sdio_pkg

/* File: src/sdio_quad.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdio_regs.svh"

module sdio_quad
	import sdio_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Actual motion.
	input wire sdio_move_t move,
	// Quadrature outputs.
	output logic phase_a,
	output logic phase_b
);

	localparam int QTR = `SDIO_FB_QTR_CYC;
	localparam int LAGQ = `SDIO_FB_LAG_CYC / `SDIO_FB_QTR_CYC;

	logic [4:0] div_r;
	logic signed [9:0] pend_r;
	logic [1:0] ph_r;
	wire qtr_en = (div_r == 5'(QTR - 1));
	wire go_up = qtr_en && (pend_r > 10'sd0);
	wire go_dn = qtr_en && (pend_r < 10'sd0);
	wire signed [9:0] add_w = move.step ? (move.cw ? 10'sd4 : -10'sd4) : 10'sd0;
	wire signed [9:0] take_w = go_up ? -10'sd1 : (go_dn ? 10'sd1 : 10'sd0);

	// Backlog is kept in quarter cycles so a reversal cancels pending travel.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 5'h0;
			pend_r <= 10'sh0;
			ph_r <= 2'h0;
			phase_a <= 1'b0;
			phase_b <= 1'b0;
		end else begin
			div_r <= qtr_en ? 5'h0 : div_r + 5'h1;
			pend_r <= pend_r + add_w + take_w;
			ph_r <= go_up ? ph_r + 2'h1 : (go_dn ? ph_r - 2'h1 : ph_r);
			phase_a <= ph_r[1] ^ ph_r[0];
			phase_b <= ph_r[1];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	fb_lag_a: assert property (pend_r <= 10'(LAGQ) && pend_r >= -10'(LAGQ))
		else $error("Feedback backlog exceeds lag bound.");
	fb_dir_a: assert property ($rose(phase_a) && $past(go_up, 2) |-> !phase_b)
		else $error("Phase B high on forward A rise.");
	fb_cov_c: cover property ($rose(phase_a) ##[1:200] $rose(phase_b));

endmodule : sdio_quad
`default_nettype wire

/* File: verif/sdio_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdio_ctl_model (
	// Clock.
	input wire logic clk,
	// Status seen by the controller.
	input wire logic ready,
	input wire logic fault_n,
	// Pulse outputs to the driver.
	output logic cw_pin,
	output logic ccw_pin
);
	initial begin
		cw_pin = 1'b0;
		ccw_pin = 1'b0;
	end

	// Pulses are spaced wide apart so the feedback backlog stays inside its lag bound.
	task automatic send(input int n, input logic cw);
		for (int i = 0; i < n; i++) begin
			if (ready === 1'b1 && fault_n === 1'b1) begin
				@(negedge clk);
				cw_pin <= cw;
				ccw_pin <= ~cw;
				repeat (3) @(negedge clk);
				cw_pin <= 1'b0;
				ccw_pin <= 1'b0;
				repeat (120) @(negedge clk);
			end
		end
	endtask : send
endmodule : sdio_ctl_model

`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import sdio_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, cw_pin, ccw_pin, excite = 1'b1, sel0 = 1'b0;
	logic home = 1'b0, preset = 1'b0, clr = 1'b0, ccs = 1'b0, res_sel = 1'b0;
	logic push_en = 1'b0, mode_cc = 1'b0, code_en = 1'b0, warn_own = 1'b0;
	logic motor_step = 1'b0, motor_cw = 1'b0, fault = 1'b0, warn = 1'b0;
	logic torque = 1'b0, push_act = 1'b0, a_prev = 1'b0, abort_seen = 1'b0, led_prev = 1'b0;
	sdio_fault_t info = '0;
	logic cmd_step, cmd_cw, busy, abort, rdy, torque_limit_flag, done, tick_d, tick_oc, warning_out, flt_n;
	logic led, cur_en, current_control_select, pha, phb;
	logic signed [31:0] pos, dev;
	logic [2:0] push_sel;
	int failures = 0, comparisons = 0, a_cw = 0, a_ccw = 0, led_chg = 0, n_step = 0, n_cw = 0;

	always #10 clk = ~clk;

	sdio_top #(.DIFF_MIN_CYC(50), .OC_MIN_CYC(200), .BLINK_CYC(8)) dut_u (
		.CORE_CLK(clk), .RST_N(rst_n), .STEP_CLOCKWISE(cw_pin),
		.STEP_COUNTERCLOCKWISE(ccw_pin), .EXCITE_IN(excite), .PUSH_CURRENT_SEL0(sel0),
		.HOME_RETURN_IN(home), .POSITION_RESET_IN(preset), .CLEAR_OR_FAULT_RESET(clr),
		.CURRENT_CONTROL_SELECT(ccs), .RESOLUTION_SELECT(res_sel), .PUSH_MODE_EN(push_en),
		.MODE_SWITCH_CC(mode_cc), .FAULT_CODE_EN(code_en), .WARN_OWN_COND_EN(warn_own),
		.TICK_STEPS(16'h0004), .MOTOR_STEP(motor_step), .MOTOR_CW(motor_cw),
		.FAULT_COND(fault), .FAULT_INFO(info), .WARNING_COND(warn), .TORQUE_OVER(torque),
		.PUSH_ACTIVE(push_act), .CMD_STEP(cmd_step), .CMD_CW(cmd_cw), .CMD_POSITION(pos),
		.DEVIATION(dev), .PUSH_CURRENT_SEL(push_sel), .CURRENT_CONTROL_MODE(current_control_select),
		.MOTOR_CURRENT_EN(cur_en), .RETURN_ABORT(abort), .RETURN_BUSY(busy),
		.READY_OR_CODE0(rdy), .TORQUE_OR_CODE1(torque_limit_flag), .MOTION_COMPLETE(done),
		.ROTATION_TICK_DIFF(tick_d), .ROTATION_TICK_OC(tick_oc), .WARNING_OUT(warning_out),
		.FAULT_OUT_N(flt_n), .FAULT_LED(led), .FEEDBACK_PHASE_A(pha), .FEEDBACK_PHASE_B(phb)
	);

	sdio_ctl_model ctl_u (
		.clk(clk), .ready(rdy), .fault_n(flt_n), .cw_pin(cw_pin), .ccw_pin(ccw_pin)
	);

	// The motor follows every command step one cycle later, so deviation returns to zero.
	always @(negedge clk) begin
		motor_step <= cmd_step;
		motor_cw <= cmd_cw;
	end

	always @(posedge clk) begin
		a_prev <= pha;
		led_prev <= led;
		if (pha === 1'b1 && a_prev === 1'b0 && phb === 1'b0) a_cw++;
		if (pha === 1'b1 && a_prev === 1'b0 && phb === 1'b1) a_ccw++;
		if (led !== led_prev) led_chg++;
		if (cmd_step === 1'b1) n_step++;
		if (cmd_step === 1'b1 && cmd_cw === 1'b1) n_cw++;
		if (abort === 1'b1) abort_seen <= 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	// The span covers every step, both home returns and all settle waits with a wide margin.
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		wrap_up();
	end

	initial begin
		wt(3);
		rst_n <= 1'b1;
		wt(10);
		check("position", pos, 32'h0);
		check("fault_n", flt_n, 1'b1);
		check("ready", rdy, 1'b1);
		check("current", cur_en, 1'b1);
		ctl_u.send(1, 1'b1);
		wt(300);
		check("position", pos, 32'h1);
		check("tick_diff", tick_d, 1'b0);
		ctl_u.send(3, 1'b1);
		wt(300);
		check("position", pos, 32'h4);
		check("tick_diff", tick_d, 1'b1);
		check("tick_oc", tick_oc, 1'b1);
		check("complete", done, 1'b1);
		check("a_cw", a_cw, 32'h4);
		ctl_u.send(1, 1'b0);
		wt(300);
		check("position", pos, 32'h3);
		check("a_ccw", a_ccw, 32'h1);
		check("cmd_steps", n_step, 32'h5);
		check("cmd_cw_steps", n_cw, 32'h4);
		clr <= 1'b1;
		ctl_u.send(2, 1'b1);
		check("position", pos, 32'h3);
		check("deviation", dev, 32'h0);
		clr <= 1'b0;
		wt(10);
		home <= 1'b1;
		wt(8);
		home <= 1'b0;
		check("busy", busy, 1'b1);
		for (int k = 0; k < 3000 && busy !== 1'b0; k++) wt(1);
		check("position", pos, 32'h0);
		ctl_u.send(2, 1'b1);
		home <= 1'b1;
		wt(20);
		home <= 1'b0;
		clr <= 1'b1;
		wt(8);
		check("abort", abort_seen, 1'b1);
		check("busy", busy, 1'b0);
		clr <= 1'b0;
		preset <= 1'b1;
		wt(10);
		check("position", pos, 32'h0);
		preset <= 1'b0;
		push_en <= 1'b1;
		for (int v = 0; v < 8; v++) begin
			{preset, home, sel0} <= v[2:0];
			wt(8);
			check("push_sel", push_sel, v[2:0]);
		end
		push_act <= 1'b1;
		wt(8);
		check("torque", torque_limit_flag, 1'b1);
		{push_en, push_act, preset, home, sel0} <= 5'h00;
		torque <= 1'b1;
		ccs <= 1'b1;
		warn_own <= 1'b1;
		warn <= 1'b1;
		wt(8);
		check("torque", torque_limit_flag, 1'b1);
		check("cc_mode", current_control_select, 1'b1);
		check("warning", warning_out, 1'b1);
		{torque, ccs, warn, warn_own} <= 4'h0;
		wt(8);
		check("torque", torque_limit_flag, 1'b0);
		check("warning", warning_out, 1'b0);
		check("cc_mode", current_control_select, 1'b0);
		mode_cc <= 1'b1;
		wt(8);
		check("cc_mode", current_control_select, 1'b1);
		mode_cc <= 1'b0;
		wt(2);
		code_en <= 1'b1;
		info <= '{resettable: 1'b1, keep_current: 1'b0, code: 3'h5};
		led_chg = 0;
		fault <= 1'b1;
		wt(30);
		check("warning", warning_out, 1'b1);
		check("fault_n", flt_n, 1'b0);
		check("current", cur_en, 1'b0);
		check("led_blinks", led_chg > 0, 1'b1);
		check("code", {tick_oc, torque_limit_flag, rdy}, 3'h5);
		fault <= 1'b0;
		clr <= 1'b1;
		wt(10);
		check("fault_n", flt_n, 1'b0);
		clr <= 1'b0;
		code_en <= 1'b0;
		wt(10);
		check("fault_n", flt_n, 1'b1);
		ctl_u.send(1, 1'b1);
		res_sel <= 1'b1;
		wt(5);
		ctl_u.send(3, 1'b1);
		wt(300);
		check("position", pos, 32'h4);
		check("tick_diff", tick_d, 1'b0);
		info <= '{resettable: 1'b0, keep_current: 1'b1, code: 3'h2};
		fault <= 1'b1;
		wt(10);
		check("fault_n", flt_n, 1'b0);
		check("current", cur_en, 1'b1);
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
